// [serial_matrix_lcd_driver_test.sv]
// Self-checking bench for the display driver and host joined on one link
`timescale 1ns/1ps
module serial_matrix_lcd_driver_test;
    logic                core_clk;
    logic                rstn = 1'b0;
    logic                drivePhase = 1'b0;
    logic [33:0]         rowPattern = 34'h3FFFFFFFF;
    logic [7:0]          rowIndex;
    logic                busy;
    logic                phaseDriven;
    sld_pkg::sld_level_e rowLevel [8];
    sld_pkg::sld_level_e colLevel [26];
    int                  badCount = 0;
    int                  totalChecks = 0;
    int                  prevIdx;
    // Newest bit is row 1, oldest bit the last column
    logic [33:0]         pats [5] = '{34'h3FFFFFFFF, 34'h000000001, 34'h200000000, 34'h1555555AA, 34'h000000000};
    sld_link_if lnk ();
    sld_driver sld_driver_inst (.core_clk(core_clk), .rstn(rstn), .link(lnk.dev), .rowLevel(rowLevel),
        .colLevel(colLevel), .phaseDriven(phaseDriven));
    sld_host sld_host_inst (.core_clk(core_clk), .rstn(rstn), .link(lnk.host), .drivePhase(drivePhase),
        .rowPattern(rowPattern), .rowIndex(rowIndex), .busy(busy));
    sld_link_props sld_link_props_inst (.core_clk(core_clk), .rstn(rstn), .shiftClk(lnk.shiftClk),
        .serialData(lnk.serialData), .phaseHostOe(lnk.phaseHostOe), .phasePin(lnk.phasePin),
        .frameReq(lnk.frameReq));
    // ==========================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic sld_pkg::sld_level_e lvl(input logic isRow, input logic b, input logic f);
        if (isRow)
            return b ? (f ? sld_pkg::SLD_LOW : sld_pkg::SLD_HIGH) : sld_pkg::SLD_MID;
        return (b == f) ? sld_pkg::SLD_HIGH : sld_pkg::SLD_LOW;
    endfunction
    // Waits for a frame level, then lets the output levels settle
    task automatic waitFrame(input logic v);
        int n;
        n = 0;
        while (lnk.frameReq !== v && n < 20000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 20000) check(8'h00, 8'h01);
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic readLevels(input logic [33:0] pat, input logic f);
        for (int r = 0; r < 8; r++)
            check(rowLevel[r], lvl(1'b1, pat[r], f));
        for (int c = 0; c < 26; c++)
            check(colLevel[c], lvl(1'b0, pat[8 + c], f));
    endtask
    // ==========================================
    // Clock, watchdog and tests
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        badCount++;
        wrapUp();
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        waitFrame(1'b1);
        waitFrame(1'b0);
        waitFrame(1'b1);
        check(phaseDriven, 8'h00);
        $display("test oscillate done");
        rstn = 1'b0;
        drivePhase = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            waitFrame(1'b1);
            check(busy, 8'h01);
            if (i > 0) readLevels(pats[i - 1], 1'b1);
            if (i > 1) check(rowIndex, 8'((prevIdx + 1) % 8));
            prevIdx = rowIndex;
            waitFrame(1'b0);
            check(busy, 8'h00);
            if (i > 0) readLevels(pats[i - 1], 1'b0);
            rowPattern = pats[(i + 1) % 5];
        end
        check(phaseDriven, 8'h01);
        $display("test transfer done");
        wrapUp();
    end
endmodule

// [sld_driver.sv]
// Display driver end: serial shift chain, display latches, phase and output drive
// What this block does
// - Shift data in on each shift clock fall
// - A one selects the element
// - Frame request rise copies chain to latches
// - Selected row opposes frame request; else midpoint
// - Column in phase if set, opposite if clear
// - Host sets frame rate times backplane count
// - Frame request is 50% square, rise transfers
// - Host shifts one row between transfers when it drives phase
// - Host takes refresh request or drives phase
// - Host selects rows one by one, in order
// - Follow driven phase, else oscillate freely until first driven
// - Cascade shares phase and shift clock
// - Alternatively gate shift clock as select
// - Host holds data steady at clock fall
// - Host keeps shift falls away from transfer when it drives phase
// - First row newest bit, last column oldest
// - Primary variant has 8 rows, 26 columns
// - Extension variant: no rows, 34 columns
`timescale 1ns/1ps
module sld_driver #(
    parameter int ROWS = sld_pkg::ROWS_PRIMARY,
    parameter int COLS = sld_pkg::COLS_PRIMARY
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    sld_link_if.dev                        link,
    output sld_pkg::sld_level_e            rowLevel [ROWS > 0 ? ROWS : 1],
    output sld_pkg::sld_level_e            colLevel [COLS],
    output logic                           phaseDriven
);
    // Chain length is rows plus columns, one stage per output
    localparam int CHAIN = ROWS + COLS;
    // ==========================================================
    // Input synchronisers
    // Shift clock, serial data and phase pin come from outside the core
    // clock; each passes two flip-flops, and the shift clock and the phase pin one more
    // so that their edges can be seen
    logic [2:0] clkSync_q;
    logic [1:0] datSync_q;
    logic [2:0] phSync_q;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            clkSync_q <= 3'h0;
        else
            clkSync_q <= {clkSync_q[1:0], link.shiftClk};
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            datSync_q <= 2'h0;
        else
            datSync_q <= {datSync_q[0], link.serialData};
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            phSync_q <= 3'h0;
        else
            phSync_q <= {phSync_q[1:0], link.phasePin};
    end
    // The data bit seen with a fall was set up half a shift period earlier
    wire shiftFall = clkSync_q[2] & ~clkSync_q[1];
    wire phaseNow  = phSync_q[1];
    wire phaseEdge = phSync_q[2] ^ phSync_q[1];
    // ==========================================================
    // Phase source: own oscillator and a check for a foreign driver
    logic [7:0] oscCnt_q;
    logic       osc_q;
    logic       driven_q;
    wire        oscWrap    = (oscCnt_q == 8'(sld_pkg::OSC_HALF_CYCLES - 1));
    wire [7:0]  oscCntD    = oscWrap ? 8'h00 : oscCnt_q + 8'h01;
    // Our own drive comes back through the pin three clocks late, so a
    // mismatch counts only once that echo has had time to arrive
    wire        oscSettled = (oscCnt_q > 8'h04);
    wire        foreignLvl = link.phaseDevOe & (phaseNow != osc_q) & ~phaseEdge & oscSettled;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            oscCnt_q <= 8'h00;
        else
            oscCnt_q <= oscCntD;
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            osc_q <= 1'b0;
        else if (oscWrap)
            osc_q <= ~osc_q;
    end
    // Once another driver wins the pin we stay off it until reset; a host
    // that then stops driving leaves the pin low and the display frozen.
    // A host waveform that matches our own oscillator exactly goes unnoticed.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            driven_q <= 1'b0;
        else if (foreignLvl)
            driven_q <= 1'b1;
    end
    // ==========================================================
    // Frame request, shift chain and display latches
    logic [CHAIN-1:0] chain_q;
    logic [CHAIN-1:0] latch_q;
    logic             frame_q;
    logic             frameD;
    logic             devOe_q;
    logic             devOut_q;
    // The frame request always follows the pin: in oscillating mode the pin
    // carries our own oscillator, so nothing glitches while the foreign
    // driver check settles after reset
    assign frameD = phaseNow;
    // Transfer is our own frame request rising, so the two never disagree
    wire transfer = frameD & ~frame_q;
    // Newest bit enters at bit 0 and the oldest walks towards the last column
    wire [CHAIN-1:0] chainD = {chain_q[CHAIN-2:0], datSync_q[1]};
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            chain_q <= '0;
        else if (shiftFall)
            chain_q <= chainD;
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            latch_q <= '0;
        else if (transfer)
            latch_q <= chain_q;
    end
    // Registered, one clock after the synchronised pin
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            frame_q <= 1'b0;
        else
            frame_q <= frameD;
    end
    // ==========================================================
    // Phase pin drive
    // The enable is high only while no other driver has been seen on the pin
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            devOe_q <= 1'b0;
        else
            devOe_q <= ~driven_q;
    end
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            devOut_q <= 1'b0;
        else
            devOut_q <= osc_q;
    end
    assign link.frameReq    = frame_q;
    assign link.phaseDevOe  = devOe_q;
    assign link.phaseDevOut = devOut_q;
    assign phaseDriven      = driven_q;
    // ==========================================================
    // Output drive; bit 0 is the newest, so it feeds the first row
    // Selected rows swing full scale against the frame request; columns
    // swing between their two levels, in phase when selected
    logic [2*ROWS+2*COLS-1:0] lvlD;
    logic [2*ROWS+2*COLS-1:0] lvl_q;
    genvar g;
    generate
        for (g = 0; g < ROWS; g++)
        begin : gRowSel
            // An unselected row rests mid-swing so it lights no column
            assign lvlD[2*g +: 2] = !latch_q[g] ? 2'(sld_pkg::SLD_MID)
                                  : (frameD ? 2'(sld_pkg::SLD_LOW) : 2'(sld_pkg::SLD_HIGH));
        end
        for (g = 0; g < COLS; g++)
        begin : gColSel
            assign lvlD[2*ROWS+2*g +: 2] = (latch_q[ROWS+g] ~^ frameD) ? 2'(sld_pkg::SLD_HIGH)
                                                                     : 2'(sld_pkg::SLD_LOW);
        end
    endgenerate
    // Registered so every output pin comes straight from a flip-flop
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            lvl_q <= '0;
        else
            lvl_q <= lvlD;
    end
    generate
        for (g = 0; g < COLS; g++)
        begin : gCol
            assign colLevel[g] = sld_pkg::sld_level_e'(lvl_q[2*ROWS+2*g +: 2]);
        end
        if (ROWS > 0)
        begin : gRow
            for (g = 0; g < ROWS; g++)
            begin : gR
                assign rowLevel[g] = sld_pkg::sld_level_e'(lvl_q[2*g +: 2]);
            end
        end
        else
        begin : gNoRow
            // The extension variant has no rows; its spare row port rests mid-swing
            assign rowLevel[0] = sld_pkg::SLD_MID;
        end
    endgenerate
endmodule

// [sld_host.sv]
// Host end: shifts one row pattern per frame request period while it drives the phase pin
`timescale 1ns/1ps
module sld_host #(
    parameter int CHAIN = sld_pkg::CHAIN_BITS,
    parameter int ROWS  = sld_pkg::ROWS_PRIMARY
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    sld_link_if.host              link,
    input  wire logic             drivePhase,
    input  wire logic [CHAIN-1:0] rowPattern,
    output logic [7:0]            rowIndex,
    output logic                  busy
);
    // ==========================================================
    logic [1:0]  frSync_q;
    logic        frPrev_q;
    logic [12:0] phCnt_q;
    logic        ph_q;
    logic [CHAIN-1:0] sh_q;
    logic [7:0]  bits_q;
    logic [4:0]  half_q;
    logic        sclk_q;
    logic        sdat_q;
    logic [7:0]  row_q;
    wire frRise  = frSync_q[1] & ~frPrev_q;
    wire halfEnd = (half_q == 5'(sld_pkg::SCLK_HALF_CYCLES - 1));
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frSync_q <= 2'h0;
            frPrev_q <= 1'b0;
            phCnt_q  <= 13'h0000;
            ph_q     <= 1'b0;
            sh_q     <= '0;
            bits_q   <= 8'h00;
            half_q   <= 5'h00;
            sclk_q   <= 1'b1;
            sdat_q   <= 1'b0;
            row_q    <= 8'h00;
        end
        else
        begin
            frSync_q <= {frSync_q[0], link.frameReq};
            frPrev_q <= frSync_q[1];
            // Equal half periods keep DC off the display
            phCnt_q <= (phCnt_q == 13'(sld_pkg::PHASE_HALF_CYCLES - 1)) ? 13'h0000 : phCnt_q + 13'h0001;
            if (phCnt_q == 13'(sld_pkg::PHASE_HALF_CYCLES - 1))
                ph_q <= ~ph_q;
            if (frRise && bits_q == 8'h00)
            begin
                // Load next row's data right after the transfer edge
                // First bit goes out now, half a shift period before the first fall
                sh_q   <= {rowPattern[CHAIN-2:0], 1'b0};
                sdat_q <= rowPattern[CHAIN-1];
                bits_q <= 8'(CHAIN);
                half_q <= 5'h00;
                row_q  <= (row_q == 8'(ROWS - 1)) ? 8'h00 : row_q + 8'h01;
            end
            else if (bits_q != 8'h00)
            begin
                half_q <= halfEnd ? 5'h00 : half_q + 5'h01;
                if (halfEnd && sclk_q)
                begin
                    sclk_q <= 1'b0;
                end
                else if (halfEnd)
                begin
                    // Data changes on rising shift clock, or when a new row loads
                    sclk_q <= 1'b1;
                    sdat_q <= sh_q[CHAIN-1];
                    sh_q   <= {sh_q[CHAIN-2:0], 1'b0};
                    bits_q <= bits_q - 8'h01;
                end
            end
        end
    end
    assign link.shiftClk     = sclk_q;
    assign link.serialData   = sdat_q;
    assign link.phaseHostOut = ph_q;
    assign link.phaseHostOe  = drivePhase;
    assign rowIndex          = row_q;
    assign busy              = bits_q != 8'h00;
endmodule

// [sld_link_if.sv]
// Wires between the display driver and the host
`timescale 1ns/1ps
interface sld_link_if;
    logic shiftClk;
    logic serialData;
    logic phaseHostOut;
    logic phaseHostOe;
    logic phaseDevOut;
    logic phaseDevOe;
    logic frameReq;
    wire  phasePin = phaseHostOe ? phaseHostOut : (phaseDevOe ? phaseDevOut : 1'b0);
    modport dev  (input shiftClk, input serialData, input phasePin, output phaseDevOut,
                  output phaseDevOe, output frameReq);
    modport host (output shiftClk, output serialData, input phasePin, output phaseHostOut,
                  output phaseHostOe, input frameReq);
endinterface

// [sld_link_props.sv]
// Concurrent checks on the link between the display driver and its host
`timescale 1ns/1ps
module sld_link_props #(
    parameter int CHAIN = sld_pkg::CHAIN_BITS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic shiftClk,
    input wire logic serialData,
    input wire logic phaseHostOe,
    input wire logic phasePin,
    input wire logic frameReq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Shift falls counted per frame period
    logic       frPrev_q;
    logic       scPrev_q;
    logic [7:0] falls_q;
    wire        frRise = frameReq & ~frPrev_q;
    wire        scFall = scPrev_q & ~shiftClk;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frPrev_q <= 1'b0;
            scPrev_q <= 1'b1;
            falls_q  <= 8'h00;
        end
        else
        begin
            frPrev_q <= frameReq;
            scPrev_q <= shiftClk;
            falls_q  <= frRise ? 8'h00 : falls_q + {7'h00, scFall};
        end
    end
    // ==========================================
    // Properties
    sequence s_quiet; shiftClk [*2]; endsequence
    sequence s_half_hi; ##[15:17] $fell(frameReq); endsequence
    sequence s_half_lo; ##[15:17] $rose(frameReq); endsequence
    property p_follow_up; phaseHostOe && $rose(phasePin) |-> ##[1:6] frameReq; endproperty
    property p_follow_dn; phaseHostOe && $fell(phasePin) |-> ##[1:6] !frameReq; endproperty
    property p_follow_lvl; (phaseHostOe && $stable(phasePin)) [*8] |-> frameReq == phasePin; endproperty
    property p_osc; !phaseHostOe && $rose(frameReq) |-> s_half_hi ##0 s_half_lo; endproperty
    property p_data; $fell(shiftClk) |-> $stable(serialData) [*4]; endproperty
    property p_gap; phaseHostOe && $rose(frameReq) |-> $past(shiftClk, 2) ##0 s_quiet; endproperty
    property p_count; frRise && phaseHostOe && falls_q != 8'h00 |-> falls_q == 8'(CHAIN); endproperty
    property p_count_max; falls_q <= 8'(CHAIN); endproperty
    a_follow_up: assert property (p_follow_up) else $error("frame request missed phase rise");
    a_follow_dn: assert property (p_follow_dn) else $error("frame request missed phase fall");
    a_follow_lvl: assert property (p_follow_lvl) else $error("frame request off phase level");
    a_osc: assert property (p_osc) else $error("oscillator halves uneven");
    a_data: assert property (p_data) else $error("serial data moved at shift fall");
    a_gap: assert property (p_gap) else $error("shift fall near transfer edge");
    a_count: assert property (p_count) else $error("wrong shift count per row");
    a_count_max: assert property (p_count_max) else $error("too many shifts in a frame");
endmodule

// [sld_pkg.sv]
// Shared constants for the serial matrix display driver and its host end
package sld_pkg;
    // Primary variant: 8 rows, 26 columns; extension variant: 0 rows, 34 columns
    localparam int ROWS_PRIMARY    = 8;
    localparam int COLS_PRIMARY    = 26;
    localparam int COLS_EXTENSION  = 34;
    localparam int CHAIN_BITS      = 34;
    // Free-running phase oscillator half period, in core clocks
    localparam int OSC_HALF_CYCLES = 16;
    // Host link: shift clock half period in core clocks (80 ns at 5 ns)
    localparam int SCLK_HALF_NS     = 80;
    localparam int CLK_PERIOD_NS    = 5;
    localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CLK_PERIOD_NS;
    // Phase half period, in core clocks, driven by the host when it drives the phase pin
    localparam int PHASE_HALF_CYCLES = 4096;
    // Not used: the driver counts the phase pin as driven at the first foreign level it sees
    localparam int DRIVEN_TIMEOUT    = 64;
    // Drive level encoding for row and column outputs
    typedef enum logic [1:0] {SLD_LOW, SLD_MID, SLD_HIGH} sld_level_e;
endpackage
